// *** src/config_store_password_lock.sv ***
// Purpose: Config store: array load, RAM staging, commit, UART access, lock
// Assumes: Host frames: R a | W a hi lo | C ; replies data/ACK/NAK bytes
// Notes:   Array modelled as a word memory; commit copies all RAM words
`timescale 1ns/1ps
module config_store_password_lock #(
   parameter int BIT_CYCLES = cfg_store_pkg::BIT_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic rx,
   output logic      tx,
   output logic      locked,
   output logic      load_done
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      S_LOAD     = 4'h0,
      S_LOADWAIT = 4'h1,
      S_CMD      = 4'h2,
      S_ADDR     = 4'h3,
      S_HI       = 4'h4,
      S_LO       = 4'h5,
      S_EXEC     = 4'h6,
      S_RDWAIT   = 4'h7,
      S_SEND     = 4'h8,
      S_COMMIT   = 4'h9,
      S_CMWAIT   = 4'hA
   } state_t;

   state_t        state;
   logic [7:0]    cmd;
   logic [6:0]    addr;
   logic [15:0]   wdata;
   logic [15:0]   password;
   logic [7:0]    idx;
   logic [23:0]   tx_queue;
   logic [1:0]    tx_count;

   mem_port_if #(.AW(cfg_store_pkg::ADDR_W), .DW(cfg_store_pkg::DATA_W)) ram_p ();
   mem_port_if #(.AW(cfg_store_pkg::ADDR_W), .DW(cfg_store_pkg::DATA_W)) nvm_p ();

   // Working RAM and nonvolatile array, 128 x 16 each
   word_mem #(.AW(cfg_store_pkg::ADDR_W), .DW(cfg_store_pkg::DATA_W)) u_ram (
      .ref_clk (ref_clk),
      .port    (ram_p)
   );
   word_mem #(.AW(cfg_store_pkg::ADDR_W), .DW(cfg_store_pkg::DATA_W)) u_nvm (
      .ref_clk (ref_clk),
      .port    (nvm_p)
   );

   ////////////////////////////////////////////////////////////////////////////
   // UART receiver, rx synchronised by two flops
   logic        rx_s1;
   logic        rx_s2;
   logic        rx_busy;
   logic [15:0] rx_cnt;
   logic [3:0]  rx_bit;
   logic [7:0]  rx_shift;
   logic        rx_valid;
   logic [7:0]  rx_byte;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= rx;
         rx_s2 <= rx_s1;
      end
   end

   // Start detect, mid-bit sampling, stop check
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rx_busy  <= 1'b0;
         rx_cnt   <= 16'h0000;
         rx_bit   <= 4'h0;
         rx_shift <= 8'h00;
         rx_valid <= 1'b0;
         rx_byte  <= 8'h00;
      end else begin
         rx_valid <= 1'b0;
         if (!rx_busy) begin
            if (!rx_s2) begin
               rx_busy <= 1'b1;
               rx_cnt  <= 16'(BIT_CYCLES / 2);
               rx_bit  <= 4'h0;
            end
         end else if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
         end else begin
            rx_cnt <= 16'(BIT_CYCLES - 1);
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_s2) begin
               rx_busy <= 1'b0; // False start
            end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
               rx_shift <= {rx_s2, rx_shift[7:1]};
            end else if (rx_bit == 4'h9) begin
               rx_busy  <= 1'b0;
               rx_valid <= rx_s2;
               rx_byte  <= rx_shift;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // UART transmitter
   logic        tx_start;
   logic [7:0]  tx_data;
   logic        tx_busy;
   logic [15:0] tx_cnt;
   logic [9:0]  tx_frame;
   logic [3:0]  tx_bit;
   logic        tx_start_hold;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_busy  <= 1'b0;
         tx_cnt   <= 16'h0000;
         tx_frame <= 10'h3FF;
         tx_bit   <= 4'h0;
         tx       <= 1'b1;
      end else if (!tx_busy) begin
         tx <= 1'b1;
         if (tx_start) begin
            tx_busy  <= 1'b1;
            tx_frame <= {1'b1, tx_data, 1'b0};
            tx_cnt   <= 16'h0000;
            tx_bit   <= 4'h0;
         end
      end else if (tx_cnt != 16'h0000) begin
         tx_cnt <= tx_cnt - 16'h0001;
      end else if (tx_bit == 4'hA) begin
         tx_busy <= 1'b0;
      end else begin
         tx       <= tx_frame[0];
         tx_frame <= {1'b1, tx_frame[9:1]};
         tx_bit   <= tx_bit + 4'h1;
         tx_cnt   <= 16'(BIT_CYCLES - 1);
      end
   end

   // Start only while reply bytes remain, else zeros would be sent forever
   assign tx_start = (state == S_SEND) && !tx_busy && !tx_start_hold
                     && (tx_count != 2'h0);
   assign tx_data  = tx_queue[23:16];

   // Blocks a second start in the cycle the transmitter turns busy
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_start_hold <= 1'b0;
      end else begin
         tx_start_hold <= tx_start;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory port steering
   always_comb begin
      ram_p.we    = 1'b0;
      ram_p.addr  = addr;
      ram_p.wdata = wdata;
      nvm_p.we    = 1'b0;
      nvm_p.addr  = idx[6:0];
      nvm_p.wdata = ram_p.rdata;
      case (state)
         S_LOAD, S_LOADWAIT: begin
            ram_p.addr  = idx[6:0]; // Same word as the array read
            ram_p.wdata = nvm_p.rdata;
            ram_p.we    = (state == S_LOADWAIT);
         end
         S_COMMIT: begin
            ram_p.addr = idx[6:0];
         end
         S_CMWAIT: begin
            ram_p.addr  = idx[6:0];
            nvm_p.we    = 1'b1;
         end
         S_EXEC: begin
            ram_p.we = (cmd == cfg_store_pkg::CMD_WRITE) && !locked
                       && (addr != cfg_store_pkg::ADDR_UNLOCK);
         end
         default: begin
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer: load, parse, execute, reply
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state    <= S_LOAD;
         idx      <= 8'h00;
         cmd      <= 8'h00;
         addr     <= 7'h00;
         wdata    <= 16'h0000;
         tx_queue <= 24'h000000;
         tx_count <= 2'h0;
      end else begin
         case (state)
            S_LOAD: begin
               state <= S_LOADWAIT;
            end
            S_LOADWAIT: begin
               idx   <= idx + 8'h01;
               state <= (idx == 8'(cfg_store_pkg::WORDS - 1)) ? S_CMD : S_LOAD;
            end
            S_CMD: begin
               if (rx_valid) begin
                  cmd <= rx_byte;
                  if (rx_byte == cfg_store_pkg::CMD_COMMIT) begin
                     state <= S_EXEC;
                  end else if (rx_byte == cfg_store_pkg::CMD_READ
                               || rx_byte == cfg_store_pkg::CMD_WRITE) begin
                     state <= S_ADDR;
                  end
               end
            end
            S_ADDR: begin
               if (rx_valid) begin
                  addr  <= rx_byte[6:0];
                  state <= (cmd == cfg_store_pkg::CMD_WRITE) ? S_HI : S_EXEC;
               end
            end
            S_HI: begin
               if (rx_valid) begin
                  wdata[15:8] <= rx_byte;
                  state       <= S_LO;
               end
            end
            S_LO: begin
               if (rx_valid) begin
                  wdata[7:0] <= rx_byte;
                  state      <= S_EXEC;
               end
            end
            S_EXEC: begin
               if (locked && !(cmd == cfg_store_pkg::CMD_WRITE
                               && addr == cfg_store_pkg::ADDR_UNLOCK)) begin
                  tx_queue <= {cfg_store_pkg::RSP_NAK, 16'h0000};
                  tx_count <= 2'h1;
                  state    <= S_SEND;
               end else if (cmd == cfg_store_pkg::CMD_READ) begin
                  state <= S_RDWAIT;
               end else if (cmd == cfg_store_pkg::CMD_COMMIT) begin
                  idx   <= 8'h00;
                  state <= S_COMMIT;
               end else begin
                  tx_queue <= {cfg_store_pkg::RSP_ACK, 16'h0000};
                  tx_count <= 2'h1;
                  state    <= S_SEND;
               end
            end
            S_RDWAIT: begin
               tx_queue <= {cfg_store_pkg::RSP_ACK, ram_p.rdata};
               tx_count <= 2'h3;
               state    <= S_SEND;
            end
            S_COMMIT: begin
               state <= S_CMWAIT;
            end
            S_CMWAIT: begin
               idx <= idx + 8'h01;
               if (idx == 8'(cfg_store_pkg::WORDS - 1)) begin
                  tx_queue <= {cfg_store_pkg::RSP_ACK, 16'h0000};
                  tx_count <= 2'h1;
                  state    <= S_SEND;
               end else begin
                  state <= S_COMMIT;
               end
            end
            S_SEND: begin
               if (tx_start) begin
                  tx_queue <= {tx_queue[15:0], 8'h00};
                  tx_count <= tx_count - 2'h1;
               end else if (tx_count == 2'h0 && !tx_busy && !tx_start_hold) begin
                  state <= S_CMD;
               end
            end
            default: begin
               state <= S_CMD;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Password shadow and lock state
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         password  <= cfg_store_pkg::PASSWORD_RST;
         locked    <= 1'b0;
         load_done <= 1'b0;
      end else begin
         if (state == S_LOADWAIT && idx == 8'(cfg_store_pkg::ADDR_PASSWORD)) begin
            password <= nvm_p.rdata; // Loaded password takes effect
            locked   <= (nvm_p.rdata != 16'h0000);
         end
         if (state == S_LOADWAIT && idx == 8'(cfg_store_pkg::WORDS - 1)) begin
            load_done <= 1'b1;
         end
         if (state == S_EXEC && cmd == cfg_store_pkg::CMD_WRITE) begin
            if (!locked && addr == cfg_store_pkg::ADDR_PASSWORD) begin
               password <= wdata;
               locked   <= (wdata != 16'h0000);
            end else if (locked && addr == cfg_store_pkg::ADDR_UNLOCK
                         && wdata == password) begin
               locked <= 1'b0;
            end
         end
      end
   end
endmodule

// *** common/cfg_store_pkg.sv ***
// Purpose: Shared constants for the configuration store with password lock
// Assumes: 16-bit words, 128-word nonvolatile array, 8N1 UART framing
// Notes:   Offsets are word addresses of the working RAM / register space
package cfg_store_pkg;
   localparam int          WORDS         = 128;
   localparam int          ADDR_W        = 7;
   localparam int          DATA_W        = 16;
   localparam logic [6:0]  ADDR_PASSWORD = 7'h01;
   localparam logic [6:0]  ADDR_UNLOCK   = 7'h7D;
   localparam logic [15:0] PASSWORD_RST  = 16'h0000;
   // UART bit time
   localparam int          CLK_HZ        = 250_000_000;
   localparam int          BAUD          = 115_200;
   localparam int          BIT_CYCLES    = CLK_HZ / BAUD;
   // Host command and reply bytes
   localparam logic [7:0]  CMD_READ      = 8'h52;
   localparam logic [7:0]  CMD_WRITE     = 8'h57;
   localparam logic [7:0]  CMD_COMMIT    = 8'h43;
   localparam logic [7:0]  RSP_ACK       = 8'h06;
   localparam logic [7:0]  RSP_NAK       = 8'h15;
endpackage

// *** common/mem_port_if.sv ***
// Purpose: Port bundle between the controller and a word memory
// Assumes: One access per cycle, read data registered
// Notes:   Used for both working RAM and nonvolatile array
`timescale 1ns/1ps
interface mem_port_if #(parameter int AW = 7, parameter int DW = 16);
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// *** src/word_mem.sv ***
// Purpose: Word memory with registered read data
// Assumes: Single port, write and read in the same cycle return old data
// Notes:   Contents are not reset; they start blank, all zero
`timescale 1ns/1ps
module word_mem #(
   parameter int AW = 7,
   parameter int DW = 16
) (
   input  wire logic ref_clk,
   mem_port_if.mem   port
);
   // Blank array reads as zero, so a fresh part powers up unlocked
   logic [DW-1:0] store [2**AW] = '{default: '0};

   // Write and registered read
   always_ff @(posedge ref_clk) begin
      if (port.we) begin
         store[port.addr] <= port.wdata;
      end
      port.rdata <= store[port.addr];
   end
endmodule

// *** sim/cfg_store_chk.sv ***
// Purpose: Port assertions for the config store
// Assumes: BIT_CYCLES equals the design instance value
// Notes:   Bound to the top module below
`timescale 1ns/1ps
module cfg_store_chk #(
   parameter int BIT_CYCLES = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rx,
   input wire logic tx,
   input wire logic locked,
   input wire logic load_done
);
   int low_run;

   // Length of the current low stretch on tx
   always_ff @(posedge ref_clk) begin
      if (!rst_n || tx) begin
         low_run <= 0;
      end else begin
         low_run <= low_run + 1;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   a_reset_idle: assert property ($rose(rst_n) |-> tx && !locked && !load_done)
      else $error("outputs not idle after reset");
   a_load_window: assert property ($rose(rst_n) |-> ##[250:400] $rose(load_done))
      else $error("array copy time wrong");
   a_load_sticky: assert property (load_done |=> load_done)
      else $error("load done dropped");
   a_quiet_loading: assert property (!load_done |-> tx)
      else $error("tx active before load");
   a_lock_reply: assert property ($rose(locked) && $past(load_done, 16) |-> ##[1:6] !tx)
      else $error("no reply after lock");
   a_unlock_reply: assert property ($fell(locked) |-> ##[1:6] !tx)
      else $error("no reply after unlock");
   a_lock_tx_idle: assert property ($changed(locked) |-> tx && $past(tx))
      else $error("lock changed during a reply");
   a_tx_bit_width: assert property ($rose(tx) |-> low_run % BIT_CYCLES == 0)
      else $error("tx bit width wrong");
endmodule

bind config_store_password_lock cfg_store_chk #(.BIT_CYCLES(BIT_CYCLES)) chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .rx(rx), .tx(tx), .locked(locked),
   .load_done(load_done));

// *** sim/uart_host_model.sv ***
// Purpose: Host side of the UART link
// Assumes: 8N1, LSB first, line idles high
// Notes:   A lost or broken reply byte reads back as unknown
`timescale 1ns/1ps
module uart_host_model #(
   parameter int BIT_CYCLES = 8
) (
   input  wire logic ref_clk,
   input  wire logic from_dev,
   output logic      to_dev
);
   // Pulled-up line idles high
   initial to_dev = 1'b1;

   // One frame from the host, then a gap
   task automatic send_byte(input logic [7:0] b, input int gap);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         to_dev <= frame[i];
         repeat (BIT_CYCLES - 1) @(posedge ref_clk);
      end
      repeat (gap) @(posedge ref_clk);
   endtask
   ////////////////////////////////////////
   // One reply frame, sampled mid bit
   task automatic recv_byte(output logic [7:0] b);
      int n;
      n = 0;
      b = 'x;
      while (from_dev !== 1'b0 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 3000)
         return;
      repeat (BIT_CYCLES / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge ref_clk);
         b[i] = from_dev;
      end
      repeat (BIT_CYCLES) @(posedge ref_clk);
      if (from_dev !== 1'b1)
         b = 'x;
      repeat (BIT_CYCLES / 2 + 1) @(posedge ref_clk);
   endtask
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the config store
// Assumes: Short bit time of 8 cycles
// Notes:   Host frames go through the partner model
`timescale 1ns/1ps
module tb;
   logic ref_clk;
   logic rst_n;
   logic rx;
   logic tx;
   logic locked;
   logic load_done;
   int   mismatches;
   int   check_count;

   config_store_password_lock #(.BIT_CYCLES(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .rx(rx), .tx(tx), .locked(locked), .load_done(load_done));
   uart_host_model #(.BIT_CYCLES(8)) host (.ref_clk(ref_clk), .from_dev(tx), .to_dev(rx));

   // 250 MHz clock
   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp1(input string what, input logic exp, input logic got);
      cmp8(what, {7'h00, exp}, {7'h00, got});
   endtask

   task automatic get(input string what, input logic [7:0] exp);
      logic [7:0] b;
      host.recv_byte(b);
      cmp8(what, exp, b);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [7:0] rsp);
      host.send_byte(cfg_store_pkg::CMD_WRITE, 0);
      host.send_byte(a, 5);
      host.send_byte(d[15:8], 0);
      host.send_byte(d[7:0], 0);
      get("write reply", rsp);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] rsp, input logic [15:0] d);
      host.send_byte(cfg_store_pkg::CMD_READ, 0);
      host.send_byte(a, 0);
      get("read reply", rsp);
      if (rsp == cfg_store_pkg::RSP_ACK) begin
         get("data high", d[15:8]);
         get("data low", d[7:0]);
      end
   endtask

   task automatic commit(input logic [7:0] rsp);
      host.send_byte(cfg_store_pkg::CMD_COMMIT, 0);
      get("commit reply", rsp);
   endtask

   task automatic do_reset;
      int n;
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      n = 0;
      while (load_done !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      cmp1("load done", 1'b1, load_done);
   endtask

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0;
      mismatches = 0;
      check_count = 0;
      do_reset();
      wr(8'h01, 16'h0000, cfg_store_pkg::RSP_ACK);
      cmp1("locked", 1'b0, locked);
      wr(8'h05, 16'h1234, cfg_store_pkg::RSP_ACK);
      wr(8'h7F, 16'hABCD, cfg_store_pkg::RSP_ACK);
      rd(8'h05, cfg_store_pkg::RSP_ACK, 16'h1234);
      commit(cfg_store_pkg::RSP_ACK);
      wr(8'h05, 16'h0000, cfg_store_pkg::RSP_ACK);
      do_reset();
      rd(8'h05, cfg_store_pkg::RSP_ACK, 16'h1234);
      rd(8'h7F, cfg_store_pkg::RSP_ACK, 16'hABCD);
      wr(8'h01, 16'hA5C3, cfg_store_pkg::RSP_ACK);
      cmp1("locked", 1'b1, locked);
      rd(8'h05, cfg_store_pkg::RSP_NAK, 16'h0000);
      wr(8'h05, 16'h0000, cfg_store_pkg::RSP_NAK);
      commit(cfg_store_pkg::RSP_NAK);
      wr(8'h7D, 16'h1111, cfg_store_pkg::RSP_ACK);
      cmp1("locked", 1'b1, locked);
      wr(8'h7D, 16'hA5C3, cfg_store_pkg::RSP_ACK);
      cmp1("locked", 1'b0, locked);
      rd(8'h05, cfg_store_pkg::RSP_ACK, 16'h1234);
      conclude();
   end

   // Hang guard
   initial begin
      repeat (40000) @(posedge ref_clk);
      mismatches++;
      conclude();
   end
endmodule
